/* bench/pin_partner.sv */
// Purpose: external clock and encoder pins
// Assumes: mode 0 idle, 1 square clock, 2 forward, 3 reverse
// Notes: one phase step every four cycles; pins stand still when idle
`timescale 1ns/100ps
module pin_partner (
   // Clock
   input wire logic clk_in,
   // Control
   input wire logic [1:0] mode_in,
   // Pins
   output logic ext_a_out,
   output logic ext_c_out
);
   logic [1:0] tick_reg = 2'h0;
   logic [1:0] phase_reg = 2'h0;
   always_ff @(posedge clk_in) begin
      tick_reg <= tick_reg + 2'h1;
      if (tick_reg == 2'h0 && mode_in != 2'h0) begin
         phase_reg <= (mode_in == 2'h3) ? phase_reg - 2'h1 : phase_reg + 2'h1;
      end
   end
   // Outside mode 1, Gray coding keeps the two pins a quarter period apart
   assign ext_a_out = phase_reg[1];
   assign ext_c_out = (mode_in == 2'h1) ? phase_reg[1] : ^phase_reg;
endmodule : pin_partner

/* bench/pulse_timer_channel_asserts.sv */
// Purpose: port checker for the pulse timer channel
// Assumes: one clock domain, asynchronous reset
// Notes: sees only the top module ports
`timescale 1ns/100ps
module pulse_timer_channel_asserts
   import pulse_timer_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Bus
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // Pins and events
   input wire logic ch4_pin_a_oe_n_out,
   input wire logic ch4_pin_b_oe_n_out,
   input wire logic ch4_overflow_out,
   input wire logic ch4_underflow_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire logic wr_done = avs_write_in && !avs_waitrequest_out;
   sequence s_ack;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence
   chk_read_ack: assert property ($rose(avs_read_in) |-> s_ack)
      else $error("read not answered in two cycles");
   chk_write_ack: assert property ($rose(avs_write_in) |-> s_ack)
      else $error("write not answered in two cycles");
   chk_wait_req: assert property (avs_waitrequest_out |-> avs_read_in || avs_write_in)
      else $error("waitrequest without a request");
   chk_read_stands: assert property (!avs_read_in |=> $stable(avs_readdata_out))
      else $error("read data moved without a read");
   chk_flow_excl: assert property (!(ch4_overflow_out && ch4_underflow_out))
      else $error("overflow and underflow together");
   chk_ovf_pulse: assert property (ch4_overflow_out |=> !ch4_overflow_out)
      else $error("overflow pulse too long");
   chk_reset_idle: assert property ($fell(rst_in) |->
      ch4_pin_a_oe_n_out && ch4_pin_b_oe_n_out && !ch4_overflow_out)
      else $error("pins not idle after reset");
   chk_oe_by_write: assert property ($changed(ch4_pin_a_oe_n_out) |->
      $past(wr_done) || $past(wr_done, 2))
      else $error("pin enable moved without a write");
endmodule : pulse_timer_channel_asserts
bind pulse_timer_channel pulse_timer_channel_asserts pulse_timer_channel_asserts_i (
   .clk_in, .rst_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
   .avs_waitrequest_out, .ch4_pin_a_oe_n_out, .ch4_pin_b_oe_n_out,
   .ch4_overflow_out, .ch4_underflow_out);

/* bench/pulse_timer_channel_tb.sv */
// Purpose: self-checking bench for the pulse timer channel
// Assumes: 20 MHz clock, bus answer awaited under a timeout
// Notes: expected intervals come from the divider table below
`timescale 1ns/100ps
module pulse_timer_channel_tb;
   import pulse_timer_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, rdq = 1'b0, wrq = 1'b0, cap_a = 1'b0;
   logic evc = 1'b0, c5o = 1'b0, syncp = 1'b0, tick3 = 1'b0;
   logic [17:0] addr = '0;
   logic [31:0] wdat = '0, rdat;
   logic [1:0] pmode = 2'h1;
   logic waitq, pa_out, pa_oe_n, pb_out, pb_oe_n, ext_a, ext_c, adc4, adc3, clr4;
   neighbour_s nb;
   int mismatches = 0, n_compared = 0, adc_n = 0, cdiv = 0, clr_n = 0, adc3_n = 0;
   int ctl_q[$] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h26, 8'h24, 8'h25, 8'h34, 8'h2c, 8'h27};
   int exp_q[$] = '{4, 16, 64, 256, 4096, 64, 64, 32, 64, 20};
   logic [15:0] idx_q[$] = '{IDX_CH4_CTRL, IDX_CH4_MODE, IDX_CH4_IOC, IDX_CH4_IER,
      IDX_CH3_IER, IDX_CH4_GRA, IDX_CH4_GRB, IDX_CH3_CNT, IDX_SYNC, 16'hfe9f, IDX_CH3_STAT};
   int rv_q[$] = '{8'h00, 8'hc0, 8'h00, 8'h40, 8'h40, 16'hffff, 16'hffff, 0, 0, 0, 8'hc0};
   // Channel 4 counter free-runs from reset, so its reset value cannot be read back
   assign nb = {evc, evc, c5o, 1'b0, syncp};
   initial forever #25 clk_in = ~clk_in;
   pin_partner pin_partner_i (.clk_in(clk_in), .mode_in(pmode), .ext_a_out(ext_a),
      .ext_c_out(ext_c));
   pulse_timer_channel pulse_timer_channel_i (.clk_in(clk_in), .rst_in(rst_in),
      .avs_address_in(addr), .avs_read_in(rdq), .avs_write_in(wrq),
      .avs_byteenable_in(4'hf), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
      .avs_waitrequest_out(waitq), .ext_clock_pin_a_in(ext_a), .ext_clock_pin_c_in(ext_c),
      .ch4_pin_a_in(pa_oe_n ? cap_a : pa_out), .ch4_pin_b_in(pb_oe_n ? 1'b0 : pb_out),
      .ch4_pin_a_out(pa_out), .ch4_pin_a_oe_n_out(pa_oe_n), .ch4_pin_b_out(pb_out),
      .ch4_pin_b_oe_n_out(pb_oe_n), .neighbour_in(nb), .ch3_count_tick_in(tick3),
      .ch4_clear_event_out(clr4), .ch4_overflow_out(), .ch4_underflow_out(),
      .ch3_adc_request_out(adc3), .ch4_adc_request_out(adc4));
   // Next channel overflows every fifth cycle, for cascaded counting
   always @(posedge clk_in) begin
      cdiv <= (cdiv == 4) ? 0 : cdiv + 1;
      c5o <= (cdiv == 4);
      if (adc4 === 1'b1) adc_n <= adc_n + 1;
      if (adc3 === 1'b1) adc3_n <= adc3_n + 1;
      if (clr4 === 1'b1) clr_n <= clr_n + 1;
   end
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [15:0] i, input logic [31:0] d,
         output logic [31:0] r);
      int n;
      @(posedge clk_in);
      addr <= {i, 2'h0};
      wdat <= d;
      if (wr) wrq <= 1'b1;
      else rdq <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (waitq !== 1'b0 && n < 50);
      r = rdat;
      rdq <= 1'b0;
      wrq <= 1'b0;
      // Later checks look at outputs once the completing edge has settled
      @(negedge clk_in);
      if (waitq !== 1'b0 && n >= 50) begin
         mismatches++;
         results();
      end
   endtask : bus
   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, i, d, x);
   endtask : wr
   task automatic rd(input logic [15:0] i, output logic [31:0] r);
      bus(1'b0, i, 32'h0, r);
   endtask : rd
   task automatic rchk(input string what, input logic [15:0] i, input logic [31:0] e);
      logic [31:0] r;
      rd(i, r);
      check(what, e, r);
   endtask : rchk
   // Times two pin edges; the first wait may start mid-period
   task automatic meas(input int e);
      int n;
      logic p;
      n = 0;
      repeat (2) begin
         p = pa_out;
         n = 0;
         while (pa_out === p && n < 20000) begin
            @(negedge clk_in);
            n++;
         end
      end
      check("toggle interval", e, n);
      if (n >= 20000) results();
   endtask : meas
   initial begin
      logic [31:0] r, c1;
      int a0;
      void'($urandom(88));
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (idx_q[k]) rchk("reset value", idx_q[k], rv_q[k]);
      wr(IDX_CH4_MODE, 32'h0f);
      rchk("mode", IDX_CH4_MODE, MODE_RESET | 8'h07);
      wr(IDX_CH4_MODE, 32'h0);
      r = $urandom & 32'hffff;
      wr(IDX_CH3_CNT, r);
      rchk("ch3 counter", IDX_CH3_CNT, r);
      wr(IDX_CH4_GRA, 32'h3);
      wr(IDX_CH4_IOC, 32'h07);
      check("initial level", 1'b1, pa_out);
      wr(IDX_CH4_IOC, 32'h03);
      check("initial level", 1'b0, pa_out);
      wr(IDX_CH4_IER, 32'h80);
      foreach (ctl_q[k]) begin
         wr(IDX_CH4_CTRL, ctl_q[k]);
         wr(IDX_CH4_CNT, 32'h0);
         meas(exp_q[k]);
      end
      check("adc requests", 1'b1, adc_n > 0);
      check("clear events", 1'b1, clr_n > 0);
      wr(IDX_CH4_IER, 32'h0);
      a0 = adc_n;
      meas(20);
      check("adc blocked", a0, adc_n);
      for (int k = 0; k < 3; k++) begin
         wr(IDX_CH4_IOC, k == 0 ? 32'h02 : (k == 1 ? 32'h05 : 32'h04));
         repeat (100) @(negedge clk_in);
         if (k < 2) check("match level", k == 0, pa_out);
         else check("pin released", 1'b1, pa_oe_n);
      end
      pmode <= 2'h0;
      wr(IDX_CH4_CTRL, 32'h60);
      wr(IDX_SYNC, 32'h10);
      wr(IDX_CH4_CNT, 32'h0);
      repeat (200) @(posedge clk_in);
      syncp <= 1'b1;
      @(posedge clk_in);
      syncp <= 1'b0;
      rd(IDX_CH4_CNT, r);
      check("sync clear", 1'b1, r < 8);
      wr(IDX_CH4_CTRL, 32'h06);
      wr(IDX_CH4_MODE, 32'h04);
      wr(IDX_CH4_CNT, 32'h0);
      @(posedge clk_in);
      pmode <= 2'h2;
      repeat (256) @(posedge clk_in);
      pmode <= 2'h0;
      rd(IDX_CH4_CNT, r);
      check("phase count up", 32'd64, r);
      @(posedge clk_in);
      pmode <= 2'h3;
      repeat (256) @(posedge clk_in);
      pmode <= 2'h0;
      rchk("phase count down", IDX_CH4_CNT, 32'h0);
      wr(IDX_CH4_MODE, 32'h0);
      wr(IDX_CH4_CTRL, 32'h0);
      wr(IDX_CH3_IER, 32'h80);
      wr(IDX_CH4_IOC, 32'hc8);
      rd(IDX_CH4_CNT, c1);
      @(posedge clk_in);
      cap_a <= 1'b1;
      evc <= 1'b1;
      @(posedge clk_in);
      evc <= 1'b0;
      rd(IDX_CH4_GRA, r);
      check("pin capture", 1'b1, r > c1 && r < 16'hffff);
      rd(IDX_CH4_GRB, r);
      check("neighbour capture", 1'b1, r > c1 && r < 16'hffff);
      check("ch3 adc request", 32'd1, adc3_n);
      wr(IDX_CH3_CNT, 32'hffff);
      @(posedge clk_in);
      tick3 <= 1'b1;
      @(posedge clk_in);
      tick3 <= 1'b0;
      rchk("ch3 rollover", IDX_CH3_CNT, 32'h0);
      wr(IDX_CH3_STAT, 32'h0);
      for (int k = 0; k < 3; k++) begin
         rd(IDX_CH3_STAT, r);
         check("overflow flag", k == 0, r[STAT_OVF_BIT]);
         wr(IDX_CH3_STAT, k == 0 ? 32'h0 : 32'hff);
      end
      results();
   end
endmodule : pulse_timer_channel_tb

/* verilog/pulse_timer_channel.sv */
// Purpose: channel 4 timer with ch3 counter, ch3 overflow flag and converter triggers
// Assumes: pins synchronous to clk_in; neighbour events are one-cycle pulses
`timescale 1ns/100ps
module pulse_timer_channel
   import pulse_timer_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Pins
   input wire logic ext_clock_pin_a_in,
   input wire logic ext_clock_pin_c_in,
   input wire logic ch4_pin_a_in,
   input wire logic ch4_pin_b_in,
   output logic ch4_pin_a_out,
   output logic ch4_pin_a_oe_n_out,
   output logic ch4_pin_b_out,
   output logic ch4_pin_b_oe_n_out,
   // Neighbour channels and converter
   input wire neighbour_s neighbour_in,
   input wire logic ch3_count_tick_in,
   output logic ch4_clear_event_out,
   output logic ch4_overflow_out,
   output logic ch4_underflow_out,
   output logic ch3_adc_request_out,
   output logic ch4_adc_request_out
);
   ctrl_s ctrl_reg;
   logic [7:0] mode_reg;
   ioc_s ioc_reg;
   logic [7:0] ier3_reg;
   logic [7:0] ier4_reg;
   logic [7:0] sync_reg;
   logic [15:0] cnt3_reg;
   logic [15:0] cnt4_reg;
   logic [15:0] gra_reg;
   logic [15:0] grb_reg;
   logic ovf3_reg;
   logic ovf3_seen_reg;
   logic ack_reg;
   logic [DIV_W-1:0] div_reg;
   logic [1:0] pin_prev_reg;
   logic [1:0] drive_en;
   logic ext_a_prev_reg;
   logic ext_c_prev_reg;
   logic [1:0] pin_level_reg;
   logic [15:0] cap_value [2];
   logic [1:0] cap_hit;
   logic [1:0] cmp_hit;
   logic [1:0] ev_hit;
   logic [1:0] is_capture;
   logic [1:0] is_compare;
   logic [1:0] pin_now;
   logic [1:0] neigh_ev;
   logic [3:0] io_code [2];
   logic phase_mode;
   logic tick_up;
   logic tick_dn;
   logic ext_sel;
   logic ext_prev;
   logic ext_rise;
   logic ext_fall;
   logic edge_hit;
   logic clear_now;
   logic [15:0] index;
   logic idx_ok;
   logic acc_go;
   logic wr_go;
   logic rd_go;
   logic [7:0] wbyte;
   logic [31:0] rd_word;
   logic ph_a_prev_reg;
   logic ph_b_prev_reg;
   logic ph_up;
   logic ph_dn;

   // Byte address is four times the printed index
   assign index = avs_address_in[ADDR_W-1:2];
   assign idx_ok = (avs_address_in[1:0] == 2'h0);
   assign acc_go = (avs_read_in | avs_write_in) & ~ack_reg;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
   // Writes land on the edge after the wait state, when the master sees waitrequest low
   assign wr_go = avs_write_in & ack_reg & avs_byteenable_in[0] & idx_ok;
   assign rd_go = avs_read_in & ~ack_reg & idx_ok;
   assign wbyte = avs_writedata_in[7:0];

   // One wait state per access keeps the read data registered
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= acc_go;
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (idx_ok) begin
         unique case (index)
            IDX_CH3_IER: rd_word[7:0] = ier3_reg;
            IDX_CH3_STAT: rd_word[7:0] = {STAT_RESET[7:5], ovf3_reg, STAT_RESET[3:0]};
            IDX_CH3_CNT: rd_word[15:0] = cnt3_reg;
            IDX_CH4_CTRL: rd_word[7:0] = ctrl_reg;
            IDX_CH4_MODE: rd_word[7:0] = mode_reg;
            IDX_CH4_IOC: rd_word[7:0] = ioc_reg;
            IDX_CH4_IER: rd_word[7:0] = ier4_reg;
            IDX_CH4_CNT: rd_word[15:0] = cnt4_reg;
            IDX_CH4_GRA: rd_word[15:0] = gra_reg;
            IDX_CH4_GRB: rd_word[15:0] = grb_reg;
            IDX_SYNC: rd_word[7:0] = sync_reg;
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in & ~ack_reg) begin
         avs_readdata_out <= rd_word;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_reg <= ctrl_s'(CTRL_RESET);
         mode_reg <= MODE_RESET;
         ioc_reg <= ioc_s'(IOC_RESET);
         ier3_reg <= IER_RESET;
         ier4_reg <= IER_RESET;
         sync_reg <= SYNC_RESET;
      end else if (wr_go) begin
         unique case (index)
            IDX_CH4_CTRL: ctrl_reg <= ctrl_s'(wbyte & CTRL_WMASK);
            // Mode bits 7:6 held at one and bits 5:3 at zero, whatever is written
            IDX_CH4_MODE: mode_reg <= (MODE_RESET & ~MODE_WMASK) | (wbyte & MODE_WMASK);
            IDX_CH4_IOC: ioc_reg <= ioc_s'(wbyte);
            IDX_CH3_IER: ier3_reg <= (IER_RESET & ~IER_WMASK) | (wbyte & IER_WMASK);
            IDX_CH4_IER: ier4_reg <= (IER_RESET & ~IER_WMASK) | (wbyte & IER_WMASK);
            IDX_SYNC: sync_reg <= wbyte;
            default: ;
         endcase
      end
   end

   // Free-running prescaler; one cycle enable per divided period
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 10'h001;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ext_a_prev_reg <= 1'b0;
         ext_c_prev_reg <= 1'b0;
         ph_a_prev_reg <= 1'b0;
         ph_b_prev_reg <= 1'b0;
      end else begin
         ext_a_prev_reg <= ext_clock_pin_a_in;
         ext_c_prev_reg <= ext_clock_pin_c_in;
         ph_a_prev_reg <= ext_clock_pin_a_in;
         ph_b_prev_reg <= ext_clock_pin_c_in;
      end
   end

   assign ext_sel = (ctrl_reg.clock_prescale_sel == PS_EXT_A) ? ext_clock_pin_a_in
                                                              : ext_clock_pin_c_in;
   assign ext_prev = (ctrl_reg.clock_prescale_sel == PS_EXT_A) ? ext_a_prev_reg
                                                               : ext_c_prev_reg;
   assign ext_rise = ext_sel & ~ext_prev;
   assign ext_fall = ~ext_sel & ext_prev;
   assign edge_hit = ctrl_reg.count_edge_sel[1] ? (ext_rise | ext_fall)
                   : (ctrl_reg.count_edge_sel[0] ? ext_fall : ext_rise);
   assign phase_mode = mode_reg[2];

   // Quadrature decode on the two external clock pins, every single-pin edge counted; a change on both pins at once is not counted
   always_comb begin
      ph_up = 1'b0;
      ph_dn = 1'b0;
      if ((ext_clock_pin_a_in != ph_a_prev_reg) || (ext_clock_pin_c_in != ph_b_prev_reg)) begin
         if ((ext_clock_pin_a_in != ph_a_prev_reg) && (ext_clock_pin_c_in != ph_b_prev_reg)) begin
            ph_up = 1'b0;
         end else if ((ext_clock_pin_a_in ^ ext_clock_pin_c_in) ^
                      (ext_clock_pin_a_in != ph_a_prev_reg)) begin
            ph_up = 1'b1;
         end else begin
            ph_dn = 1'b1;
         end
      end
   end

   always_comb begin
      tick_up = 1'b0;
      tick_dn = 1'b0;
      if (phase_mode) begin
         tick_up = ph_up;
         tick_dn = ph_dn;
      end else begin
         unique case (ctrl_reg.clock_prescale_sel)
            PS_DIV1: tick_up = 1'b1;
            PS_DIV4: tick_up = ((div_reg & DIV4_MASK) == DIV4_MASK);
            PS_DIV16: tick_up = ((div_reg & DIV16_MASK) == DIV16_MASK);
            PS_DIV64: tick_up = ((div_reg & DIV64_MASK) == DIV64_MASK);
            PS_EXT_A, PS_EXT_C: tick_up = edge_hit;
            PS_DIV1024: tick_up = ((div_reg & DIV1024_MASK) == DIV1024_MASK);
            PS_CASCADE: begin
               tick_up = neighbour_in.ch5_overflow;
               tick_dn = neighbour_in.ch5_underflow;
            end
         endcase
      end
   end

   // Per-register compare and capture
   assign io_code[0] = ioc_reg.reg_a_io_code;
   assign io_code[1] = ioc_reg.reg_b_io_code;
   assign pin_now = {ch4_pin_b_in, ch4_pin_a_in};
   assign neigh_ev = {neighbour_in.ch3_reg_c_event, neighbour_in.ch3_reg_a_event};
   assign cap_value[0] = gra_reg;
   assign cap_value[1] = grb_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_prev_reg <= 2'b00;
      end else begin
         pin_prev_reg <= pin_now;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_reg
         logic rise;
         logic fall;
         assign is_compare[gi] = ~io_code[gi][3];
         assign is_capture[gi] = io_code[gi][3];
         assign rise = pin_now[gi] & ~pin_prev_reg[gi];
         assign fall = ~pin_now[gi] & pin_prev_reg[gi];
         always_comb begin
            cap_hit[gi] = 1'b0;
            if (io_code[gi][3:2] == 2'b11) begin
               cap_hit[gi] = neigh_ev[gi];
            end else if (io_code[gi][3:2] == 2'b10) begin
               cap_hit[gi] = io_code[gi][1] ? (rise | fall)
                           : (io_code[gi][0] ? fall : rise);
            end
         end
         assign cmp_hit[gi] = is_compare[gi] & tick_up & (cnt4_reg == cap_value[gi]);
         assign ev_hit[gi] = cmp_hit[gi] | cap_hit[gi];
         always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               pin_level_reg[gi] <= 1'b0;
            end else if (wr_go && (index == IDX_CH4_IOC)) begin
               pin_level_reg[gi] <= (gi == 0) ? wbyte[2] : wbyte[6];
            end else if (cmp_hit[gi]) begin
               unique case (io_code[gi][1:0])
                  2'b00: pin_level_reg[gi] <= pin_level_reg[gi];
                  2'b01: pin_level_reg[gi] <= 1'b0;
                  2'b10: pin_level_reg[gi] <= 1'b1;
                  2'b11: pin_level_reg[gi] <= ~pin_level_reg[gi];
               endcase
            end
         end
         assign drive_en[gi] = is_compare[gi] & (io_code[gi][1:0] != 2'b00);
      end
   endgenerate

   assign ch4_pin_a_out = pin_level_reg[0];
   assign ch4_pin_b_out = pin_level_reg[1];
   assign ch4_pin_a_oe_n_out = ~drive_en[0];
   assign ch4_pin_b_oe_n_out = ~drive_en[1];

   always_comb begin
      unique case (ctrl_reg.counter_clear_src)
         CLR_NONE: clear_now = 1'b0;
         CLR_REG_A: clear_now = ev_hit[0];
         CLR_REG_B: clear_now = ev_hit[1];
         CLR_SYNC: clear_now = sync_reg[SYNC_CH4_BIT] & neighbour_in.sync_clear;
      endcase
   end

   // General registers: software write, capture load wins over it
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         gra_reg <= GR_RESET;
         grb_reg <= GR_RESET;
      end else begin
         if (cap_hit[0]) begin
            gra_reg <= cnt4_reg;
         end else if (avs_byteenable_in[1:0] == 2'b11 && wr_go && index == IDX_CH4_GRA) begin
            gra_reg <= avs_writedata_in[15:0];
         end
         if (cap_hit[1]) begin
            grb_reg <= cnt4_reg;
         end else if (avs_byteenable_in[1:0] == 2'b11 && wr_go && index == IDX_CH4_GRB) begin
            grb_reg <= avs_writedata_in[15:0];
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt4_reg <= CNT_RESET;
      end else if (clear_now) begin
         cnt4_reg <= CNT_RESET;
      end else if (wr_go && index == IDX_CH4_CNT && avs_byteenable_in[1:0] == 2'b11) begin
         cnt4_reg <= avs_writedata_in[15:0];
      end else if (tick_up) begin
         cnt4_reg <= cnt4_reg + 16'h0001;
      end else if (tick_dn) begin
         cnt4_reg <= cnt4_reg - 16'h0001;
      end
   end

   assign ch4_clear_event_out = clear_now & (ctrl_reg.counter_clear_src != CLR_SYNC);
   assign ch4_overflow_out = tick_up & (cnt4_reg == CNT_MAX);
   assign ch4_underflow_out = tick_dn & (cnt4_reg == CNT_RESET);
   assign ch4_adc_request_out = ier4_reg[IER_ADC_BIT] & ev_hit[0];
   assign ch3_adc_request_out = ier3_reg[IER_ADC_BIT] & neighbour_in.ch3_reg_a_event;

   // Neighbour counter, up only, with its overflow flag
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt3_reg <= CNT_RESET;
      end else if (wr_go && index == IDX_CH3_CNT && avs_byteenable_in[1:0] == 2'b11) begin
         cnt3_reg <= avs_writedata_in[15:0];
      end else if (ch3_count_tick_in) begin
         cnt3_reg <= cnt3_reg + 16'h0001;
      end
   end

   // Set beats clear; a 0 write clears only once the 1 was read
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ovf3_reg <= 1'b0;
         ovf3_seen_reg <= 1'b0;
      end else if (ch3_count_tick_in && cnt3_reg == CNT_MAX) begin
         ovf3_reg <= 1'b1;
      end else if (rd_go && index == IDX_CH3_STAT && ovf3_reg) begin
         ovf3_seen_reg <= 1'b1;
      end else if (wr_go && index == IDX_CH3_STAT && !wbyte[STAT_OVF_BIT] && ovf3_seen_reg) begin
         ovf3_reg <= 1'b0;
         ovf3_seen_reg <= 1'b0;
      end
   end
endmodule : pulse_timer_channel

/* verilog/pulse_timer_pkg.sv */
// Purpose: constants and carrier types for the pulse timer channel
// Assumes: 32-bit Avalon-MM word per register, byte addresses from printed offsets
// Notes: printed offsets are not all multiples of four, so they are indices
package pulse_timer_pkg;
   localparam logic [15:0] IDX_CH3_IER = 16'hfe84;
   localparam logic [15:0] IDX_CH3_CNT = 16'hfe86;
   localparam logic [15:0] IDX_CH4_CTRL = 16'hfe90;
   localparam logic [15:0] IDX_CH4_MODE = 16'hfe91;
   localparam logic [15:0] IDX_CH4_IOC = 16'hfe92;
   localparam logic [15:0] IDX_CH4_IER = 16'hfe94;
   localparam logic [15:0] IDX_CH3_STAT = 16'hfe85;
   localparam logic [15:0] IDX_CH4_CNT = 16'hfe96;
   localparam logic [15:0] IDX_CH4_GRA = 16'hfe98;
   localparam logic [15:0] IDX_CH4_GRB = 16'hfe9a;
   localparam logic [15:0] IDX_SYNC = 16'hfe81;
   localparam int ADDR_W = 18;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'hc0;
   localparam logic [7:0] IOC_RESET = 8'h00;
   localparam logic [7:0] IER_RESET = 8'h40;
   localparam logic [7:0] STAT_RESET = 8'hc0;
   localparam logic [7:0] SYNC_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] GR_RESET = 16'hffff;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam int IER_ADC_BIT = 7;
   localparam int STAT_OVF_BIT = 4;
   localparam int SYNC_CH4_BIT = 4;
   localparam logic [7:0] MODE_WMASK = 8'h07;
   localparam logic [7:0] CTRL_WMASK = 8'h7f;
   localparam logic [7:0] IER_WMASK = 8'h80;
   localparam int DIV_W = 10;
   localparam logic [9:0] DIV4_MASK = 10'h003;
   localparam logic [9:0] DIV16_MASK = 10'h00f;
   localparam logic [9:0] DIV64_MASK = 10'h03f;
   localparam logic [9:0] DIV1024_MASK = 10'h3ff;
   typedef enum logic [2:0] {
      PS_DIV1 = 3'h0, PS_DIV4 = 3'h1, PS_DIV16 = 3'h2, PS_DIV64 = 3'h3,
      PS_EXT_A = 3'h4, PS_EXT_C = 3'h5, PS_DIV1024 = 3'h6, PS_CASCADE = 3'h7
   } prescale_e;
   typedef enum logic [1:0] {
      CLR_NONE = 2'h0, CLR_REG_A = 2'h1, CLR_REG_B = 2'h2, CLR_SYNC = 2'h3
   } clear_src_e;
   typedef enum logic [3:0] {
      MD_NORMAL = 4'h0, MD_RSVD = 4'h1, MD_PWM1 = 4'h2, MD_PWM2 = 4'h3,
      MD_PHASE1 = 4'h4, MD_PHASE2 = 4'h5, MD_PHASE3 = 4'h6, MD_PHASE4 = 4'h7
   } mode_e;
   typedef struct packed {
      logic reserved;
      clear_src_e counter_clear_src;
      logic [1:0] count_edge_sel;
      prescale_e clock_prescale_sel;
   } ctrl_s;
   typedef struct packed {
      logic [3:0] reg_b_io_code;
      logic [3:0] reg_a_io_code;
   } ioc_s;
   // Neighbour events that arrive as pulses from the adjacent channels
   typedef struct packed {
      logic ch3_reg_a_event;
      logic ch3_reg_c_event;
      logic ch5_overflow;
      logic ch5_underflow;
      logic sync_clear;
   } neighbour_s;
endpackage : pulse_timer_pkg
